// [bench/ppg_bus_model.sv]
// core bus and module clock model for the strobe gating block
// assumes the bench steers it through plain levels; pins are asynchronous
`timescale 1ns/10ps
module ppg_bus_model
(
    // steering from the bench
    input wire logic por_i,
    input wire logic run_clk_i,
    input wire logic run_ale_i,
    input wire logic ale_lvl_i,
    input wire logic [2:0] strobe_n_i,
    input wire logic cs_n_i,
    // pins toward the block
    output logic mck_o,
    output logic ale_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic program_store_enable_n_o,
    output logic cs_n_o
);
    initial
    begin
        mck_o = 1'b0;
        ale_o = 1'b0;
    end
    // phase unrelated to the system clock; parks low between bursts
    always #53 mck_o = run_clk_i ? ~mck_o : 1'b0;
    always #30 ale_o = run_ale_i ? ~ale_o : ale_lvl_i;
    // write strobe parked high through power-on reset
    assign wr_n_o = por_i ? 1'b1 : strobe_n_i[0];
    assign rd_n_o = strobe_n_i[1];
    assign program_store_enable_n_o = strobe_n_i[2];
    assign cs_n_o = cs_n_i;
endmodule

// [bench/ppg_top_tb.sv]
// self-checking bench for the strobe gating and reset status block
// assumes the bus model stands in for the core; reads are judged by a monitor
`timescale 1ns/10ps
module ppg_top_tb;
    localparam logic [7:0] MAP_CFG = 8'h5b;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, warm = 1'b0, busy = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, g, s, e;
    logic run_clk = 1'b0, run_ale = 1'b0, ale_lvl = 1'b0, cs_n = 1'b1, rd_seen = 1'b0;
    logic [2:0] strobe_n = 3'h7;
    logic mck, ale, wr_n, rd_n, program_store_enable_n, chip_n, a_wr, a_rd, a_ps, a_ale, a_blk;
    logic f_smr, f_ab, f_rdm, pd, ok, lv, mc, cio, atri, ptri;
    logic [7:0] exp_q[$];
    int error_cnt = 0, checks_done = 0, mck_edges = 0, n;
    integer seed = 32'h3187;

    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge mck) mck_edges++;

    ppg_bus_model bus (.por_i(rst_i), .run_clk_i(run_clk), .run_ale_i(run_ale),
        .ale_lvl_i(ale_lvl), .strobe_n_i(strobe_n), .cs_n_i(cs_n), .mck_o(mck),
        .ale_o(ale), .wr_n_o(wr_n), .rd_n_o(rd_n), .program_store_enable_n_o(program_store_enable_n), .cs_n_o(chip_n));

    ppg_top #(.MAP_CONFIG(MAP_CFG)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .warm_rst_i(warm), .module_input_clock_i(mck), .ale_i(ale),
        .wr_n_i(wr_n), .rd_n_i(rd_n), .program_store_enable_n_i(program_store_enable_n),
        .chip_sel_n_i(chip_n), .array_wr_n_o(a_wr), .array_rd_n_o(a_rd),
        .array_program_store_enable_n_o(a_ps), .array_ale_o(a_ale),
        .array_addr_block_o(a_blk), .flash_busy_i(busy), .flash_sm_reset_o(f_smr),
        .flash_abort_o(f_ab), .flash_read_mode_o(f_rdm), .power_down_o(pd),
        .mem_access_ok_o(ok), .logic_valid_o(lv), .macrocell_clear_o(mc),
        .core_io_input_mode_o(cio), .addr_out_tristate_o(atri), .periph_tristate_o(ptri));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(x);
        @(posedge clk_sys_i);
        rd <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk_sys_i)
    begin
        if (rd_seen && exp_q.size() > 0)
            check("rdata", rdata, exp_q.pop_front());
        rd_seen <= rd;
    end

    function automatic logic pick(input int sel);
        case (sel)
            0: pick = ok;
            1: pick = pd;
            default: pick = f_ab;
        endcase
    endfunction

    task automatic wait_sig(input int sel, input logic v);
        n = 0;
        while (pick(sel) !== v && n < 3000)
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        if (n >= 3000)
        begin
            error_cnt++;
            $display("wrong value wait %0d expected %b seen timeout", sel, v);
            tally_and_finish();
        end
    endtask

    task automatic por();
        // let a pending read answer be judged before reset wipes it
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
        check("por pins", {mc, lv, f_rdm, f_smr, cio, atri, ptri, ok}, 8'hbe);
        check("por strobes", {4'h0, a_ale, a_ps, a_rd, a_wr}, 8'h07);
        @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1;
        wait_sig(0, 1'b1);
        e = 8'(ppg_pkg::CFG_LOAD_CYCLES + ppg_pkg::OPR_CYCLES);
        check("recovery", n[7:0], e);
    endtask

    // counting restarts from a parked clock so the edge tally is exact
    task automatic idle_run();
        // a stale tick from before parking must not shorten the tally
        wreg(ppg_pkg::OFS_POWER_MGMT_FIRST, 8'h00);
        wreg(ppg_pkg::OFS_POWER_MGMT_FIRST, 8'h02);
        mck_edges = 0;
        run_clk <= 1'b1;
        wait_sig(1, 1'b1);
        check("idle edges", mck_edges[7:0], 8'(ppg_pkg::IDLE_LIMIT));
    endtask

    initial
    begin
        por();
        rreg(ppg_pkg::OFS_POWER_MGMT_FIRST, 8'h00);
        rreg(ppg_pkg::OFS_STROBE_GATE, 8'h00);
        rreg(ppg_pkg::OFS_MEM_MAP, MAP_CFG & ppg_pkg::MAP_CLEAR_MASK);
        rreg(ppg_pkg::OFS_STATUS, 8'h1c);
        rreg(8'h20, 8'h00);
        wreg(ppg_pkg::OFS_STROBE_GATE, 8'hff);
        wreg(ppg_pkg::OFS_STATUS, 8'hff);
        rreg(ppg_pkg::OFS_STROBE_GATE, ppg_pkg::STROBE_GATE_MASK);
        rreg(ppg_pkg::OFS_STATUS, 8'h1c);
        $display("test registers done");
        for (int i = 0; i < 12; i++)
        begin
            g = 8'($random(seed)) & ppg_pkg::STROBE_GATE_MASK;
            s = 8'($random(seed));
            wreg(ppg_pkg::OFS_STROBE_GATE, g);
            strobe_n <= s[2:0];
            ale_lvl <= s[3];
            repeat (6) @(posedge clk_sys_i);
            #1;
            e = {4'h0, ~g[5] & s[3], g[4] | s[2], g[3] | s[1], g[2] | s[0]};
            check("array strobes", {4'h0, a_ale, a_ps, a_rd, a_wr}, e);
        end
        wreg(ppg_pkg::OFS_STROBE_GATE, 8'h00);
        $display("test gating done");
        strobe_n <= 3'h7;
        ale_lvl <= 1'b0;
        wreg(ppg_pkg::OFS_POWER_MGMT_FIRST, 8'h02);
        idle_run();
        check("pd pins", {3'h0, a_blk, ptri, ok, cio, atri}, 8'h18);
        rreg(ppg_pkg::OFS_STATUS, 8'h19);
        run_ale <= 1'b1;
        wait_sig(1, 1'b0);
        repeat (300) @(posedge clk_sys_i);
        #1;
        check("pulsing ale", {6'h0, pd, ok}, 8'h01);
        @(posedge clk_sys_i);
        run_clk <= 1'b0;
        run_ale <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        idle_run();
        @(posedge clk_sys_i);
        run_clk <= 1'b0;
        cs_n <= 1'b0;
        wait_sig(1, 1'b0);
        repeat (3) @(posedge clk_sys_i);
        #1;
        check("cs wake", {6'h0, pd, ok}, 8'h01);
        wreg(ppg_pkg::OFS_POWER_MGMT_FIRST, 8'h00);
        cs_n <= 1'b1;
        run_clk <= 1'b1;
        repeat (300) @(posedge clk_sys_i);
        #1;
        check("disabled", {7'h0, pd}, 8'h00);
        run_clk <= 1'b0;
        $display("test idle done");
        wreg(ppg_pkg::OFS_POWER_MGMT_FIRST, 8'h02);
        wreg(ppg_pkg::OFS_STROBE_GATE, 8'h14);
        wreg(ppg_pkg::OFS_MEM_MAP, 8'hff);
        busy <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
        check("busy read mode", {7'h0, f_rdm}, 8'h00);
        @(posedge clk_sys_i);
        warm <= 1'b1;
        #1;
        wait_sig(2, 1'b1);
        check("warm pins", {f_smr, lv, mc, cio, atri, ptri, ok, 1'b0}, 8'hdc);
        @(posedge clk_sys_i);
        #1;
        check("abort pulse", {7'h0, f_ab}, 8'h00);
        @(posedge clk_sys_i);
        warm <= 1'b0;
        busy <= 1'b0;
        #1;
        wait_sig(0, 1'b1);
        check("warm recovery", {7'h0, n >= ppg_pkg::OPR_CYCLES}, 8'h01);
        check("read mode", {7'h0, f_rdm}, 8'h01);
        rreg(ppg_pkg::OFS_POWER_MGMT_FIRST, 8'h02);
        rreg(ppg_pkg::OFS_STROBE_GATE, 8'h14);
        rreg(ppg_pkg::OFS_MEM_MAP, MAP_CFG & ppg_pkg::MAP_CLEAR_MASK);
        $display("test warm reset done");
        por();
        rreg(ppg_pkg::OFS_STROBE_GATE, 8'h00);
        rreg(ppg_pkg::OFS_POWER_MGMT_FIRST, 8'h00);
        $display("test second power-on done");
        repeat (3) @(posedge clk_sys_i);
        tally_and_finish();
    end
endmodule

// [src/ppg_idle_counter.sv]
// idle counter that raises the power-down request
// assumes tick_i is a one-cycle pulse per rising edge of the module input clock
`timescale 1ns/10ps
module ppg_idle_counter
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // control
    input wire logic enable_i,
    input wire logic clear_i,
    input wire logic tick_i,
    // result
    output logic power_down_request_o
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (!enable_i || clear_i)
            cnt_nxt = 4'h0;
        else if (tick_i && cnt_r != 4'(ppg_pkg::IDLE_LIMIT))
            cnt_nxt = cnt_r + 4'h1;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_r <= 4'h0;
        else
            cnt_r <= cnt_nxt;
    end

    assign power_down_request_o = (cnt_r == 4'(ppg_pkg::IDLE_LIMIT));

    a_pdn_needs_enable: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(power_down_request_o) |-> $past(enable_i) && $past(tick_i) && !$past(clear_i))
        else $error("power-down request rose without enabled idle tick");
    a_clear_drops_pdn: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (clear_i || !enable_i) |=> !power_down_request_o ##1 !power_down_request_o)
        else $error("idle counter not restarted by strobe activity");
    c_pdn_raised: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(power_down_request_o));
endmodule

// [src/ppg_pkg.sv]
// constants for the logic-array power gating and reset status block
// assumes one 100 MHz system clock; all figures below except IDLE_LIMIT, which counts module clock edges, are referred to it
package ppg_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // recovery time after any reset release (minimum, rounded up)
    localparam int unsigned OPR_TIME_NS = 200;
    localparam int unsigned OPR_CYCLES = (OPR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CFG_LOAD_CYCLES = 16;
    localparam int unsigned IDLE_LIMIT = 15;
    localparam int unsigned CNT_W = 5;

    // register map, byte offsets
    localparam logic [7:0] OFS_POWER_MGMT_FIRST = 8'h00;
    localparam logic [7:0] OFS_STROBE_GATE = 8'h08;
    localparam logic [7:0] OFS_MEM_MAP = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // field positions
    localparam int unsigned BIT_AUTO_PD = 1;
    localparam int unsigned BIT_GATE_WR = 2;
    localparam int unsigned BIT_GATE_RD = 3;
    localparam int unsigned BIT_GATE_PROGRAM_STORE_ENABLE = 4;
    localparam int unsigned BIT_GATE_ALE = 5;
    localparam int unsigned BIT_CODE_SOURCE = 0;
    localparam int unsigned BIT_PERIPH_MODE = 1;

    // writable bits and values after reset
    localparam logic [7:0] PMC_FIRST_MASK = 8'h3a;
    localparam logic [7:0] STROBE_GATE_MASK = 8'h3c;
    localparam logic [7:0] PMC_RESET = 8'h00;
    localparam logic [7:0] MAP_CLEAR_MASK = 8'hfc;
    // idle levels of {warm, cs_n, program_store_enable_n, rd_n, wr_n, ale, module clock}
    localparam logic [6:0] PIN_IDLE = 7'h3c;

    // gray codes along cfg -> recover -> run -> power-down
    typedef enum logic [2:0] {
        ST_CFG = 3'h0,
        ST_RECOVER = 3'h1,
        ST_RUN = 3'h3,
        ST_PDOWN = 3'h2,
        ST_WRST = 3'h6
    } ppg_state_t;
endpackage

// [src/ppg_top.sv]
// power gating of core strobes into the logic array, idle power-down and reset status
// assumes strobe, chip-select, warm-reset and module clock pins are asynchronous;
// rst_i is the power-on reset, registers are reached over a plain strobe port
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
module ppg_top
#(
    parameter logic [7:0] MAP_CONFIG = 8'h00
)
(
    // clock and power-on reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // pins from the core and board
    input wire logic warm_rst_i,
    input wire logic module_input_clock_i,
    input wire logic ale_i,
    input wire logic wr_n_i,
    input wire logic rd_n_i,
    input wire logic program_store_enable_n_i,
    input wire logic chip_sel_n_i,
    // strobes seen by the logic array
    output logic array_wr_n_o,
    output logic array_rd_n_o,
    output logic array_program_store_enable_n_o,
    output logic array_ale_o,
    output logic array_addr_block_o,
    // flash control
    input wire logic flash_busy_i,
    output logic flash_sm_reset_o,
    output logic flash_abort_o,
    output logic flash_read_mode_o,
    // status and port control
    output logic power_down_o,
    output logic mem_access_ok_o,
    output logic logic_valid_o,
    output logic macrocell_clear_o,
    output logic core_io_input_mode_o,
    output logic addr_out_tristate_o,
    output logic periph_tristate_o
);
    localparam int unsigned NSYNC = 7;

    logic [NSYNC-1:0] pins;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    logic [NSYNC-1:0] prev_r;
    logic clk_s, ale_s, wr_n_s, rd_n_s, program_store_enable_n_s, cs_n_s, warm_s;
    logic clk_tick, ale_toggle, power_down_request;

    ppg_pkg::ppg_state_t state_r, state_nxt;
    logic [ppg_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [7:0] pmc_first_r, pmc_first_nxt;
    logic [7:0] strobe_gate_r, strobe_gate_nxt;
    logic [7:0] map_r, map_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [3:0] array_r, array_nxt;
    logic abort_r, abort_nxt;
    logic read_mode_r, read_mode_nxt;
    logic in_reset, in_reset_nxt;

    assign pins = {warm_rst_i, chip_sel_n_i, program_store_enable_n_i, rd_n_i, wr_n_i,
                   ale_i, module_input_clock_i};

    // every pin gets its own two-stage synchroniser; the third stage feeds edge detection
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            always_ff @(posedge clk_sys_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    // park at idle levels so release shows no false strobe or edge
                    sync1_r[gi] <= ppg_pkg::PIN_IDLE[gi];
                    sync2_r[gi] <= ppg_pkg::PIN_IDLE[gi];
                    prev_r[gi] <= ppg_pkg::PIN_IDLE[gi];
                end
                else
                begin
                    sync1_r[gi] <= pins[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    prev_r[gi] <= sync2_r[gi];
                end
            end
        end
    endgenerate

    assign {warm_s, cs_n_s, program_store_enable_n_s, rd_n_s, wr_n_s, ale_s, clk_s} = sync2_r;
    assign clk_tick = clk_s && !prev_r[0];
    assign ale_toggle = ale_s ^ prev_r[1];

    // idle counter runs only while the module is up; any wake cause clears it
    ppg_idle_counter u_idle
    (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .enable_i(pmc_first_r[ppg_pkg::BIT_AUTO_PD]),
        .clear_i(ale_toggle || !cs_n_s || warm_s || in_reset),
        .tick_i(clk_tick),
        .power_down_request_o(power_down_request)
    );

    // reset sequencing
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            ppg_pkg::ST_CFG:
            begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == ppg_pkg::CNT_W'(ppg_pkg::CFG_LOAD_CYCLES - 1))
                begin
                    state_nxt = ppg_pkg::ST_RECOVER;
                    cnt_nxt = '0;
                end
            end
            ppg_pkg::ST_RECOVER:
            begin
                cnt_nxt = cnt_r + 1'b1;
                if (warm_s)
                    state_nxt = ppg_pkg::ST_WRST;
                else if (cnt_r == ppg_pkg::CNT_W'(ppg_pkg::OPR_CYCLES - 1))
                    state_nxt = ppg_pkg::ST_RUN;
            end
            ppg_pkg::ST_RUN:
            begin
                if (warm_s)
                    state_nxt = ppg_pkg::ST_WRST;
                else if (power_down_request)
                    state_nxt = ppg_pkg::ST_PDOWN;
            end
            ppg_pkg::ST_PDOWN:
            begin
                if (warm_s)
                    state_nxt = ppg_pkg::ST_WRST;
                else if (!power_down_request)
                    state_nxt = ppg_pkg::ST_RUN;
            end
            ppg_pkg::ST_WRST:
            begin
                cnt_nxt = '0;
                if (!warm_s)
                    state_nxt = ppg_pkg::ST_RECOVER;
            end
            default:
            begin
                state_nxt = ppg_pkg::ST_CFG;
                cnt_nxt = '0;
            end
        endcase
    end

    assign in_reset = (state_r == ppg_pkg::ST_CFG) || (state_r == ppg_pkg::ST_WRST);
    assign in_reset_nxt = (state_nxt == ppg_pkg::ST_CFG) || (state_nxt == ppg_pkg::ST_WRST);

    // registers, strobe gating and flash side
    always_comb
    begin
        pmc_first_nxt = pmc_first_r;
        strobe_gate_nxt = strobe_gate_r;
        map_nxt = map_r;
        rdata_nxt = 8'h00;
        if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                ppg_pkg::OFS_POWER_MGMT_FIRST:
                    pmc_first_nxt = reg_wdata_i & ppg_pkg::PMC_FIRST_MASK;
                ppg_pkg::OFS_STROBE_GATE:
                    strobe_gate_nxt = reg_wdata_i & ppg_pkg::STROBE_GATE_MASK;
                ppg_pkg::OFS_MEM_MAP:
                    map_nxt = reg_wdata_i;
                default:
                    ;
            endcase
        end
        // warm reset leaves both power registers alone
        if (state_r == ppg_pkg::ST_WRST)
            map_nxt = MAP_CONFIG & ppg_pkg::MAP_CLEAR_MASK;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                ppg_pkg::OFS_POWER_MGMT_FIRST:
                    rdata_nxt = pmc_first_r;
                ppg_pkg::OFS_STROBE_GATE:
                    rdata_nxt = strobe_gate_r;
                ppg_pkg::OFS_MEM_MAP:
                    rdata_nxt = map_r;
                ppg_pkg::OFS_STATUS:
                    rdata_nxt = {3'h0, logic_valid_o, read_mode_r, mem_access_ok_o,
                                 in_reset, power_down_o};
                default:
                    rdata_nxt = 8'h00;
            endcase
        end
        // a cut strobe sits at its inactive level so the array sees no toggling
        array_nxt[0] = strobe_gate_r[ppg_pkg::BIT_GATE_WR] ? 1'b1 : wr_n_s;
        array_nxt[1] = strobe_gate_r[ppg_pkg::BIT_GATE_RD] ? 1'b1 : rd_n_s;
        array_nxt[2] = strobe_gate_r[ppg_pkg::BIT_GATE_PROGRAM_STORE_ENABLE] ? 1'b1 : program_store_enable_n_s;
        array_nxt[3] = strobe_gate_r[ppg_pkg::BIT_GATE_ALE] ? 1'b0 : ale_s;
        abort_nxt = in_reset_nxt && !in_reset && flash_busy_i;
        read_mode_nxt = in_reset_nxt ? 1'b1 : !flash_busy_i;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= ppg_pkg::ST_CFG;
            cnt_r <= '0;
            pmc_first_r <= ppg_pkg::PMC_RESET;
            strobe_gate_r <= ppg_pkg::PMC_RESET;
            map_r <= MAP_CONFIG & ppg_pkg::MAP_CLEAR_MASK;
            rdata_r <= 8'h00;
            array_r <= 4'h7;
            abort_r <= 1'b0;
            read_mode_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pmc_first_r <= pmc_first_nxt;
            strobe_gate_r <= strobe_gate_nxt;
            map_r <= map_nxt;
            rdata_r <= rdata_nxt;
            array_r <= array_nxt;
            abort_r <= abort_nxt;
            read_mode_r <= read_mode_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign {array_ale_o, array_program_store_enable_n_o, array_rd_n_o, array_wr_n_o} = array_r;
    assign power_down_o = (state_r == ppg_pkg::ST_PDOWN);
    assign array_addr_block_o = power_down_o;
    assign mem_access_ok_o = (state_r == ppg_pkg::ST_RUN);
    assign logic_valid_o = (state_r != ppg_pkg::ST_CFG);
    assign macrocell_clear_o = (state_r == ppg_pkg::ST_CFG);
    assign flash_sm_reset_o = in_reset;
    assign flash_abort_o = abort_r;
    assign flash_read_mode_o = read_mode_r;
    assign core_io_input_mode_o = in_reset;
    assign addr_out_tristate_o = in_reset;
    assign periph_tristate_o = in_reset || power_down_o;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_wr_gate_cut: assert property (strobe_gate_r[2] |=> array_wr_n_o)
        else $error("gated write strobe not held inactive");
    a_rd_gate_pass: assert property (!strobe_gate_r[3] |=> array_rd_n_o == $past(rd_n_s))
        else $error("connected read strobe not passed to array");
    a_program_store_enable_gate_cut: assert property (strobe_gate_r[4] ##1 strobe_gate_r[4]
        |-> array_program_store_enable_n_o)
        else $error("gated program-store strobe not held inactive");
    a_ale_gate_cut: assert property (strobe_gate_r[5] |=> !array_ale_o)
        else $error("gated address latch not held low");
    a_warm_keeps_pmc: assert property ((state_r == ppg_pkg::ST_WRST && !reg_wr_i)
        |=> $stable(strobe_gate_r) && $stable(pmc_first_r))
        else $error("warm reset altered power registers");
    a_recovery_done: assert property ($rose(mem_access_ok_o)
        |-> $past(state_r) == ppg_pkg::ST_PDOWN
            || ($past(state_r) == ppg_pkg::ST_RECOVER
            && $past(cnt_r) == ppg_pkg::CNT_W'(ppg_pkg::OPR_CYCLES - 1)))
        else $error("accesses allowed before recovery period");
    a_warm_valid: assert property (state_r == ppg_pkg::ST_WRST
        |-> logic_valid_o && !macrocell_clear_o)
        else $error("logic outputs invalid during warm reset");
    a_flash_abort: assert property ((flash_busy_i && state_r == ppg_pkg::ST_RUN && warm_s)
        |=> flash_abort_o ##1 flash_read_mode_o)
        else $error("reset did not abort flash cycle");
    a_map_reload: assert property (state_r == ppg_pkg::ST_WRST
        |=> map_r[1:0] == 2'h0)
        else $error("mapping register mode bits not cleared");

    c_power_down: cover property (state_r == ppg_pkg::ST_RUN ##1 state_r == ppg_pkg::ST_PDOWN);
    c_wake: cover property (power_down_o ##1 mem_access_ok_o);
    c_warm: cover property (state_r == ppg_pkg::ST_WRST ##1 state_r == ppg_pkg::ST_RECOVER);
endmodule
